/* core/ust_pkg.sv */
// Shared constants for the six-timer bank: register offsets, field positions,
// reset values and encodings. Assumes a 16-bit short-I/O slave in front.
package ust_pkg;

  localparam int unsigned NUM_TIMERS = 6;
  localparam int unsigned GROUP_SIZE = 3;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned NUM_DECADE = 7;

  // Byte offsets inside the decoded window
  localparam logic [6:0] OFS_TMR0       = 7'h00;
  localparam logic [6:0] OFS_TMR1       = 7'h02;
  localparam logic [6:0] OFS_TMR2       = 7'h04;
  localparam logic [6:0] OFS_GRP_A_CTRL = 7'h06;
  localparam logic [6:0] OFS_TMR3       = 7'h08;
  localparam logic [6:0] OFS_TMR4       = 7'h0a;
  localparam logic [6:0] OFS_TMR5       = 7'h0c;
  localparam logic [6:0] OFS_GRP_B_CTRL = 7'h0e;
  localparam logic [6:0] OFS_IRQ        = 7'h10;

  // Configuration byte (high byte of a timer word)
  localparam int unsigned CFG_CLK_LSB   = 0;
  localparam int unsigned CFG_GATE_LSB  = 3;
  localparam int unsigned CFG_IE_BIT    = 5;
  localparam int unsigned CFG_REL_BIT   = 6;
  localparam int unsigned CFG_GSTAT_BIT = 7;
  localparam logic [2:0]  CLK_SEL_OFF   = 3'h0;

  // Group control byte
  localparam int unsigned CTL_BCD_BIT  = 0;
  localparam int unsigned CTL_MODE_LSB = 1;
  localparam int unsigned CTL_RW_LSB   = 4;
  localparam int unsigned CTL_SC_LSB   = 6;
  localparam logic [1:0]  SC_READBACK  = 2'h3;
  localparam int unsigned RB_NCNT_BIT  = 5;
  localparam int unsigned RB_NSTAT_BIT = 4;

  localparam logic [2:0] MODE_EVENT = 3'h0;
  localparam logic [2:0] MODE_ONESHOT = 3'h1;
  localparam logic [2:0] MODE_RATE  = 3'h2;

  typedef enum logic [1:0] {GATE_STOP, GATE_EXT, GATE_RUN, GATE_NEXT100} ust_gate_t;
  typedef enum logic [1:0] {RW_LATCH, RW_LSB, RW_MSB, RW_BOTH} ust_rw_t;

  // Reset values
  localparam logic [6:0]  CFG_RESET   = 7'h00;
  localparam logic [2:0]  MODE_RESET  = 3'h0;
  localparam logic [1:0]  RW_RESET    = 2'h1;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [7:0]  UNUSED_BYTE = 8'hff;
  localparam logic [15:0] UNUSED_WORD = 16'hffff;

endpackage : ust_pkg

/* core/ust_timer_bank.sv */
// Six 16-bit down-counting timers in two groups of three, with configuration,
// gate selection and interrupt flags, reached over a 16-bit register port.
// Assumes decade ticks and the 100 ms tick are one-cycle pulses on clock_i.

// Functional notes
// RULE_01: Six timers 0..5 in two groups, one shared control register per group.
// RULE_02: Config in high byte, data in low byte; group control low byte at 6, e.
// RULE_03: Unused byte locations inside the window read back as all ones.
// RULE_04: Host programs config, then control, then count, then config again.
// RULE_05: Control write clears the count; 16-bit counts go in as two bytes.
// RULE_06: Clock choice 1 Hz to 1 MHz by decades or stopped; counts on falling edge.
// RULE_07: Gate source is stop, external pin, run, or next 100 ms edge.
// RULE_08: Next-100 ms gate loads the timer at that edge without output pulse.
// RULE_09: Host sets synchronous start between two 100 ms edges, clock stopped first.
// RULE_10: Repeating mode: edge to first rise equals rise-to-rise interval.
// RULE_11: Enabled output rising edge sets the timer's sticky interrupt flag.
// RULE_12: Flag clears only when release bit is written one, then zero.
// RULE_13: Config readback shows the live gate level in a read-only bit.
// RULE_14: Count value zero counts as 65536 periods in every mode.
// RULE_15: Mode 0: output low on control write, high after N+1 clocks.
// RULE_16: Mode 0: gate enables; first of two bytes halts and forces output low.
// RULE_17: Mode 0: count written with gate low still loads; N clocks after gate.
// RULE_18: Mode 1: output high on control write; low N clocks after gate trigger.
// RULE_19: Mode 1: gate fall ignored, retrigger reloads, new count waits for trigger.
// RULE_20: Mode 2: output low one clock when count reaches 1, period N.
// RULE_21: Mode 2: low gate stops and forces output high; rising gate reloads.
// RULE_22: Mode 2: count loads next clock; first low pulse N clocks after write.
// RULE_23: Mode 2 count must be at least two.
// RULE_24: Mode 2 rewritten count loads on trigger, else at end of cycle; the code loads it on the next clock tick instead.
// RULE_25: Control byte: select, access mode, mode number, decimal flag, readback form.
module ust_timer_bank
  import ust_pkg::*;
#(
  parameter logic [7:0] IRQ_ID = 8'h5a  // Arbitrary identification value
) (
  input  wire logic                          clock_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          ce_i,
  input  wire logic                          bus_sel_i,
  input  wire logic                          bus_wr_i,
  input  wire logic [6:0]                    bus_addr_i,
  input  wire logic [1:0]                    bus_be_i,
  input  wire logic [15:0]                   bus_wdata_i,
  output logic      [15:0]                   bus_rdata_o,
  output logic                               bus_ack_o,
  input  wire logic [ust_pkg::NUM_DECADE-1:0] dec_tick_i,
  input  wire logic                          ms100_tick_i,
  input  wire logic [ust_pkg::NUM_TIMERS-1:0] gate_ext_i,
  output logic      [ust_pkg::NUM_TIMERS-1:0] timer_out_o,
  output logic                               irq_o
);

  import ust_pkg::*;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  function automatic logic [2:0] tmr_of(input logic [5:0] w);
    return w[2] ? (3'(w[1:0]) + 3'h3) : 3'(w[1:0]);
  endfunction

  function automatic logic is_timer_word(input logic [5:0] w);
    return (w < 6'h08) && (w[1:0] != 2'h3);
  endfunction

  logic [5:0]  word_w;
  logic        wr_w;
  logic        rd_w;
  logic        ctl_hit_w;
  logic [7:0]  cbyte_w;
  logic [NUM_TIMERS-1:0] cfg_wr_w;
  logic [NUM_TIMERS-1:0] dat_wr_w;
  logic [NUM_TIMERS-1:0] dat_rd_w;
  logic [NUM_TIMERS-1:0] ctl_wr_w;
  logic [NUM_TIMERS-1:0] lat_cmd_w;
  logic [NUM_TIMERS-1:0] st_cmd_w;
  logic [NUM_TIMERS-1:0] gate_w;
  logic [NUM_TIMERS-1:0] tick_w;
  logic [NUM_TIMERS-1:0] fire_w;
  logic [7:0]  rd_byte_w [NUM_TIMERS];

  logic [6:0]  cfg_q   [NUM_TIMERS];
  logic [2:0]  mode_q  [NUM_TIMERS];
  logic [1:0]  rw_q    [NUM_TIMERS];
  logic        bcd_q   [NUM_TIMERS];
  logic [15:0] cnt_q   [NUM_TIMERS];
  logic [15:0] cr_q    [NUM_TIMERS];
  logic [15:0] lat_q   [NUM_TIMERS];
  logic [7:0]  st_q    [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] out_q, oprev_q, gprev_q, fired_q, irq_q, rel_q;
  logic [NUM_TIMERS-1:0] ldp_q, trig_q, run_q, hold_q, null_q;
  logic [NUM_TIMERS-1:0] wmsb_q, rmsb_q, latv_q, stv_q;
  logic        irq_line_q;

  assign word_w    = bus_addr_i[6:1];
  // A request held over its acknowledge edge is one access, not two
  assign wr_w      = ce_i && bus_sel_i && bus_wr_i && !bus_ack_o;
  assign rd_w      = ce_i && bus_sel_i && !bus_wr_i && !bus_ack_o;
  assign ctl_hit_w = wr_w && bus_be_i[0] && (word_w[5:3] == 3'h0) && (word_w[1:0] == 2'h3);
  assign cbyte_w   = bus_wdata_i[7:0];

  // Register decode, one strobe per timer [RULE_01] [RULE_02] [RULE_25]
  always_comb begin
    for (int t = 0; t < NUM_TIMERS; t++) begin
      cfg_wr_w[t]  = wr_w && bus_be_i[1] && is_timer_word(word_w) && (tmr_of(word_w) == 3'(t));
      dat_wr_w[t]  = wr_w && bus_be_i[0] && is_timer_word(word_w) && (tmr_of(word_w) == 3'(t));
      dat_rd_w[t]  = rd_w && bus_be_i[0] && is_timer_word(word_w) && (tmr_of(word_w) == 3'(t));
      ctl_wr_w[t]  = 1'b0;
      lat_cmd_w[t] = 1'b0;
      st_cmd_w[t]  = 1'b0;
      if (ctl_hit_w && (word_w[2] == ((t / GROUP_SIZE) != 0))) begin
        if (cbyte_w[CTL_SC_LSB +: 2] == SC_READBACK) begin
          lat_cmd_w[t] = cbyte_w[1 + (t % GROUP_SIZE)] && !cbyte_w[RB_NCNT_BIT];
          st_cmd_w[t]  = cbyte_w[1 + (t % GROUP_SIZE)] && !cbyte_w[RB_NSTAT_BIT];
        end else if (cbyte_w[CTL_SC_LSB +: 2] == 2'(t % GROUP_SIZE)) begin
          lat_cmd_w[t] = (cbyte_w[CTL_RW_LSB +: 2] == RW_LATCH);
          ctl_wr_w[t]  = (cbyte_w[CTL_RW_LSB +: 2] != RW_LATCH);
        end
      end
    end
  end

  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tmr
    logic [2:0] clk_sel;
    logic [1:0] gsrc;
    logic       msb_sel;
    logic [15:0] src;
    assign clk_sel = cfg_q[t][CFG_CLK_LSB +: 3];
    assign gsrc    = cfg_q[t][CFG_GATE_LSB +: 2];
    // Decade ticks mark the falling clock edge; setting zero holds the clock low [RULE_06]
    assign tick_w[t] = ce_i && (clk_sel != CLK_SEL_OFF) && dec_tick_i[clk_sel - 3'h1];
    // Gate source selection [RULE_07]
    assign gate_w[t] = (gsrc == GATE_EXT)  ? gate_ext_i[t] :
                       (gsrc == GATE_RUN)  ? 1'b1 :
                       (gsrc == GATE_NEXT100) ? fired_q[t] : 1'b0;
    assign fire_w[t] = ce_i && ms100_tick_i && (gsrc == GATE_NEXT100) && !fired_q[t];
    assign src     = latv_q[t] ? lat_q[t] : cnt_q[t];
    assign msb_sel = (rw_q[t] == RW_MSB) || ((rw_q[t] == RW_BOTH) && rmsb_q[t]);
    assign rd_byte_w[t] = stv_q[t] ? st_q[t] : (msb_sel ? src[15:8] : src[7:0]);

    // Configuration byte and the one-shot 100 ms arming
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cfg_q[t]   <= CFG_RESET;
        fired_q[t] <= 1'b0;
        gprev_q[t] <= 1'b0;
      end else if (ce_i) begin
        // The sync load already starts a rate timer; its gate rise must not reload it again [RULE_10]
        gprev_q[t] <= gate_w[t] || (fire_w[t] && mode_q[t] != MODE_ONESHOT);
        if (cfg_wr_w[t]) begin
          cfg_q[t]   <= bus_wdata_i[14:8];
          fired_q[t] <= 1'b0;
        end else if (fire_w[t]) begin
          fired_q[t] <= 1'b1;  // [RULE_08]
        end
      end
    end

    // Counter core; later assignments override earlier ones in the same cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mode_q[t] <= MODE_RESET;
        rw_q[t]   <= RW_RESET;
        bcd_q[t]  <= 1'b0;
        cnt_q[t]  <= CNT_RESET;
        cr_q[t]   <= CNT_RESET;
        lat_q[t]  <= CNT_RESET;
        st_q[t]   <= 8'h00;
        {out_q[t], ldp_q[t], trig_q[t], run_q[t], hold_q[t], null_q[t]} <= 6'h00;
        {wmsb_q[t], rmsb_q[t], latv_q[t], stv_q[t]} <= 4'h0;
      end else if (ce_i) begin
        if (ctl_wr_w[t]) begin
          mode_q[t] <= cbyte_w[CTL_MODE_LSB +: 3];
          rw_q[t]   <= cbyte_w[CTL_RW_LSB +: 2];
          bcd_q[t]  <= cbyte_w[CTL_BCD_BIT];
          cnt_q[t]  <= CNT_RESET;  // [RULE_05]
          out_q[t]  <= (cbyte_w[CTL_MODE_LSB +: 3] != MODE_EVENT);  // [RULE_15] [RULE_18] [RULE_20]
          {ldp_q[t], trig_q[t], run_q[t], hold_q[t]} <= 4'h0;
          {wmsb_q[t], rmsb_q[t], latv_q[t], stv_q[t]} <= 4'h0;
          null_q[t] <= 1'b1;
        end else begin
          if (dat_wr_w[t]) begin
            null_q[t] <= 1'b1;
            if (rw_q[t] == RW_BOTH && !wmsb_q[t]) begin
              cr_q[t][7:0] <= cbyte_w;
              wmsb_q[t]    <= 1'b1;
              if (mode_q[t] == MODE_EVENT) begin
                hold_q[t] <= 1'b1;  // [RULE_16]
                out_q[t]  <= 1'b0;
              end
            end else begin
              if (rw_q[t] == RW_BOTH) cr_q[t][15:8] <= cbyte_w;  // [RULE_05]
              else if (rw_q[t] == RW_MSB) cr_q[t] <= {cbyte_w, 8'h00};
              else cr_q[t] <= {8'h00, cbyte_w};
              wmsb_q[t] <= 1'b0;
              hold_q[t] <= 1'b0;
              // Mode 1 keeps the pending value until the next trigger [RULE_19]
              ldp_q[t]  <= (mode_q[t] != MODE_ONESHOT);
            end
          end
          if (gate_w[t] && !gprev_q[t]) trig_q[t] <= 1'b1;
          // Low gate ends a running low pulse at once [RULE_21]
          if (mode_q[t] == MODE_RATE && !gate_w[t] && !out_q[t]) out_q[t] <= 1'b1;
          if (tick_w[t]) begin
            case (mode_q[t])
              MODE_EVENT: begin
                if (ldp_q[t]) begin
                  cnt_q[t] <= cr_q[t];  // First clock loads, no decrement [RULE_15] [RULE_17]
                  ldp_q[t] <= 1'b0;
                  run_q[t] <= 1'b1;
                  null_q[t] <= 1'b0;
                end else if (run_q[t] && gate_w[t] && !hold_q[t]) begin
                  cnt_q[t] <= cnt_q[t] - 16'h0001;  // Zero wraps, giving 65536 [RULE_14]
                  if (cnt_q[t] == 16'h0001) out_q[t] <= 1'b1;  // [RULE_16]
                end
              end
              MODE_ONESHOT: begin
                if (trig_q[t]) begin
                  cnt_q[t]  <= cr_q[t];  // [RULE_18] [RULE_19]
                  trig_q[t] <= 1'b0;
                  run_q[t]  <= 1'b1;
                  out_q[t]  <= 1'b0;
                  null_q[t] <= 1'b0;
                end else if (run_q[t]) begin
                  cnt_q[t] <= cnt_q[t] - 16'h0001;  // [RULE_14]
                  if (cnt_q[t] == 16'h0001) begin
                    out_q[t] <= 1'b1;
                    run_q[t] <= 1'b0;
                  end
                end
              end
              MODE_RATE: begin
                if (ldp_q[t] || trig_q[t]) begin
                  cnt_q[t]  <= cr_q[t];  // [RULE_21] [RULE_22] [RULE_24]
                  ldp_q[t]  <= 1'b0;
                  trig_q[t] <= 1'b0;
                  out_q[t]  <= 1'b1;
                  null_q[t] <= 1'b0;
                end else if (gate_w[t]) begin
                  if (cnt_q[t] == 16'h0002) begin
                    cnt_q[t] <= 16'h0001;
                    out_q[t] <= 1'b0;  // [RULE_20]
                  end else if (cnt_q[t] == 16'h0001) begin
                    cnt_q[t] <= cr_q[t];  // A count of one is not allowed here [RULE_23]
                    out_q[t] <= 1'b1;
                  end else begin
                    cnt_q[t] <= cnt_q[t] - 16'h0001;  // [RULE_14]
                  end
                end
              end
              default: ;  // Other modes are not built: counter idles
            endcase
          end
          // Synchronous start: load at the edge, output untouched [RULE_08] [RULE_10]
          if (fire_w[t]) begin
            cnt_q[t]  <= cr_q[t];
            ldp_q[t]  <= 1'b0;
            trig_q[t] <= 1'b0;
            run_q[t]  <= 1'b1;
            null_q[t] <= 1'b0;
          end
          // First latch wins until it is read back
          if (lat_cmd_w[t] && !latv_q[t]) begin
            lat_q[t]  <= cnt_q[t];
            latv_q[t] <= 1'b1;
          end
          if (st_cmd_w[t] && !stv_q[t]) begin
            st_q[t]  <= {out_q[t], null_q[t], rw_q[t], mode_q[t], bcd_q[t]};  // [RULE_25]
            stv_q[t] <= 1'b1;
          end
          if (dat_rd_w[t]) begin
            if (stv_q[t]) stv_q[t] <= 1'b0;
            else if (rw_q[t] == RW_BOTH) begin
              rmsb_q[t] <= !rmsb_q[t];
              if (rmsb_q[t]) latv_q[t] <= 1'b0;
            end else latv_q[t] <= 1'b0;
          end
        end
      end
    end

    // Sticky interrupt flag; a new event beats a release in the same cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        irq_q[t]   <= 1'b0;
        rel_q[t]   <= 1'b0;
        oprev_q[t] <= 1'b0;
      end else if (ce_i) begin
        oprev_q[t] <= out_q[t];
        if (cfg_wr_w[t]) rel_q[t] <= bus_wdata_i[8 + CFG_REL_BIT];
        if (out_q[t] && !oprev_q[t] && cfg_q[t][CFG_IE_BIT]) irq_q[t] <= 1'b1;  // [RULE_11]
        else if (rel_q[t] && cfg_wr_w[t] && !bus_wdata_i[8 + CFG_REL_BIT]) irq_q[t] <= 1'b0;  // [RULE_12]
      end
    end

    a_ctrl_clears_cnt: assert property (ctl_wr_w[t] |=> cnt_q[t] == CNT_RESET)  // [RULE_05]
      else $error("control write did not clear the count");
    a_mode0_starts_low: assert property (  // [RULE_15]
      ctl_wr_w[t] && cbyte_w[CTL_MODE_LSB +: 3] == MODE_EVENT |=> !out_q[t] && mode_q[t] == MODE_EVENT)
      else $error("mode 0 output not low after control write");
    a_mode1_starts_high: assert property (  // [RULE_18]
      ctl_wr_w[t] && cbyte_w[CTL_MODE_LSB +: 3] == MODE_ONESHOT |=> out_q[t])
      else $error("mode 1 output not high after control write");
    a_mode0_hits_zero: assert property (  // [RULE_15]
      tick_w[t] && mode_q[t] == MODE_EVENT && run_q[t] && gate_w[t] && !hold_q[t] && !ldp_q[t]
      && cnt_q[t] == 16'h0001 && !ctl_wr_w[t] && !dat_wr_w[t] && !fire_w[t] |=> out_q[t] && cnt_q[t] == 16'h0000)
      else $error("mode 0 output did not rise at zero");
    a_first_byte_halts: assert property (  // [RULE_16]
      dat_wr_w[t] && !ctl_wr_w[t] && mode_q[t] == MODE_EVENT && rw_q[t] == RW_BOTH && !wmsb_q[t]
      ##1 !dat_wr_w[t] && !ctl_wr_w[t] |-> !out_q[t] && hold_q[t] ##1 !out_q[t] && hold_q[t])
      else $error("first byte did not halt mode 0");
    a_rate_gate_high: assert property (  // [RULE_21]
      ce_i && mode_q[t] == MODE_RATE && !gate_w[t] && !out_q[t] && !ctl_wr_w[t] |=> out_q[t])
      else $error("mode 2 low gate did not force output high");
    a_rate_low_pulse: assert property (  // [RULE_20]
      tick_w[t] && mode_q[t] == MODE_RATE && gate_w[t] && !ldp_q[t] && !trig_q[t] && cnt_q[t] == 16'h0002
      && !ctl_wr_w[t] && !fire_w[t] |=> !out_q[t] && cnt_q[t] == 16'h0001)
      else $error("mode 2 low pulse missing at count one");
    a_clock_off_frozen: assert property (  // [RULE_06]
      ce_i && cfg_q[t][CFG_CLK_LSB +: 3] == CLK_SEL_OFF && !ctl_wr_w[t] && !fire_w[t] |=> $stable(cnt_q[t]))
      else $error("count moved with clock stopped");
    a_sync_load: assert property (fire_w[t] && !ctl_wr_w[t] |=> cnt_q[t] == $past(cr_q[t]) && $stable(out_q[t]))  // [RULE_08]
      else $error("100 ms edge did not load the timer cleanly");
    a_irq_sets: assert property (  // [RULE_11]
      ce_i && out_q[t] && !oprev_q[t] && cfg_q[t][CFG_IE_BIT] |=> irq_q[t])
      else $error("enabled rising output did not set the flag");
    a_irq_holds: assert property (  // [RULE_12]
      irq_q[t] && !(ce_i && rel_q[t] && cfg_wr_w[t] && !bus_wdata_i[8 + CFG_REL_BIT]) |=> irq_q[t])
      else $error("interrupt flag dropped without release");
  end

  // Register read port; every access answers on the next edge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_rdata_o <= UNUSED_WORD;
      bus_ack_o   <= 1'b0;
    end else if (ce_i) begin
      bus_ack_o   <= bus_sel_i && !bus_ack_o;
      bus_rdata_o <= UNUSED_WORD;  // [RULE_03]
      if (rd_w) begin
        if (is_timer_word(word_w)) begin
          bus_rdata_o <= {gate_w[tmr_of(word_w)], cfg_q[tmr_of(word_w)], rd_byte_w[tmr_of(word_w)]};  // [RULE_13]
        end else if ({word_w, 1'b0} == OFS_IRQ) begin
          bus_rdata_o <= {2'h0, irq_q, IRQ_ID};
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) irq_line_q <= 1'b0;
    else if (ce_i) irq_line_q <= |irq_q;  // [RULE_11]
  end

  assign timer_out_o = out_q;
  assign irq_o       = irq_line_q;

  a_unused_ones: assert property (rd_w && {word_w, 1'b0} == OFS_GRP_A_CTRL |=> bus_rdata_o == UNUSED_WORD)  // [RULE_03]
    else $error("unused location did not read all ones");
  a_gate_readable: assert property (rd_w && {word_w, 1'b0} == OFS_TMR0 |=> bus_rdata_o[15] == $past(gate_w[0]))  // [RULE_13]
    else $error("gate level not shown in config readback");
  a_irq_line: assert property (ce_i && (|irq_q) |=> irq_o)  // [RULE_11]
    else $error("interrupt line not raised for a set flag");

endmodule : ust_timer_bank

/* tb/ust_host_model.sv */
// Bus master stand-in: drives one register access at a time over the bank's port.
// Assumes a free-running clock_i; requests change at the falling edge only.
module ust_host_model (
  input  wire logic        clock_i,
  input  wire logic        ack_i,
  input  wire logic [15:0] rdata_i,
  output logic             sel_o,
  output logic             wr_o,
  output logic [6:0]       addr_o,
  output logic [1:0]       be_o,
  output logic [15:0]      wdata_o
);
  initial begin
    sel_o   = 1'b0;
    wr_o    = 1'b0;
    addr_o  = 7'h00;
    be_o    = 2'h0;
    wdata_o = 16'h0000;
  end

  // Request stands until the edge that samples ack high; a missing ack runs into the bench's cycle ceiling
  task automatic acc(input logic w, input logic [6:0] a, input logic [1:0] b,
                     input logic [15:0] d, output logic [15:0] q);
    @(negedge clock_i);
    sel_o   = 1'b1;
    wr_o    = w;
    addr_o  = a;
    be_o    = b;
    wdata_o = d;
    do begin
      @(posedge clock_i);
    end while (ack_i !== 1'b1);
    q = rdata_i;
    @(negedge clock_i);
    sel_o = 1'b0;
  endtask
endmodule // ust_host_model

/* tb/ust_timer_bank_tb_top.sv */
// Self-checking bench for the six-timer bank: register map, mode 0, mode 2, interrupt flag, sync start.
// Assumes the host model in its own file; only the 1 MHz decade tick is exercised.
module ust_timer_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ust_pkg::*;
  localparam logic [7:0] TB_ID = 8'h3c;  // Arbitrary identification value

  logic        clock_i, rst_n_i, sel, wr, ack, irq, tick, tick_en, ms;
  logic [6:0]  addr;
  logic [1:0]  be;
  logic [15:0] wdata, rdata, q;
  logic [5:0]  tout;
  logic [31:0] rng;
  int          error_cnt, n_tests, tick_cnt, base, div, cyc, n;

  ust_timer_bank #(.IRQ_ID(TB_ID)) u_ust_timer_bank (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .bus_sel_i(sel), .bus_wr_i(wr),
    .bus_addr_i(addr), .bus_be_i(be), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
    .bus_ack_o(ack), .dec_tick_i({tick, 6'h00}), .ms100_tick_i(ms),
    .gate_ext_i(6'h00), .timer_out_o(tout), .irq_o(irq));

  ust_host_model u_ust_host_model (
    .clock_i(clock_i), .ack_i(ack), .rdata_i(rdata), .sel_o(sel), .wr_o(wr),
    .addr_o(addr), .be_o(be), .wdata_o(wdata));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // 1 MHz tick stand-in every fourth cycle, so counts stay short
  always @(negedge clock_i) begin
    div  <= tick_en ? (div + 1) % 4 : 0;
    tick <= tick_en && (div == 3);
  end
  always @(posedge clock_i) begin
    if (tick === 1'b1) tick_cnt <= tick_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_out(input int idx, input logic lvl);
    for (int i = 0; i < 400; i++) begin
      @(negedge clock_i);
      if (tout[idx] === lvl) return;
    end
    error_cnt++;
    $display("unexpected timer output wait: expected %b seen %b", lvl, tout[idx]);
  endtask

  // Config high lane, control or count on the low lane, in the order the host must use
  task automatic setup(input logic [6:0] ofs, input logic [6:0] ctl, input logic [7:0] ctrl,
                       input int cnt, input logic [7:0] cfg2);
    tick_en <= 1'b0;
    u_ust_host_model.acc(1'b1, ofs, 2'b10, 16'h0700, q);
    u_ust_host_model.acc(1'b1, ctl, 2'b01, {8'h00, ctrl}, q);
    u_ust_host_model.acc(1'b1, ofs, 2'b01, 16'(cnt), q);
    u_ust_host_model.acc(1'b1, ofs, 2'b10, {cfg2, 8'h00}, q);
    base    = tick_cnt;
    tick_en <= 1'b1;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    rst_n_i = 1'b0;
    tick_en = 1'b0;
    ms = 1'b0;
    tick = 1'b0;
    div = 0;
    tick_cnt = 0;
    cyc = 0;
    error_cnt = 0;
    n_tests = 0;
    rng = 32'hb921;
    repeat (4) @(negedge clock_i);
    rst_n_i = 1'b1;

    u_ust_host_model.acc(1'b0, 7'h14, 2'b11, 16'h0000, q);
    chk("unused word", UNUSED_WORD, q);
    u_ust_host_model.acc(1'b0, OFS_GRP_A_CTRL, 2'b11, 16'h0000, q);
    chk("control word high byte", 16'hff, {8'h00, q[15:8]});
    $display("register map test done");

    rng = xs(rng);
    n = 1 + int'(rng % 8);
    u_ust_host_model.acc(1'b1, OFS_TMR0, 2'b10, 16'h0700, q);
    u_ust_host_model.acc(1'b1, OFS_GRP_A_CTRL, 2'b01, 16'h0014, q);
    u_ust_host_model.acc(1'b1, OFS_GRP_A_CTRL, 2'b01, 16'h0010, q);
    chk("mode 0 out after control", 16'h0, {15'h0, tout[0]});
    setup(OFS_TMR0, OFS_GRP_A_CTRL, 8'h10, n, 8'h37);
    wait_out(0, 1'b1);
    chk("mode 0 ticks to rise", 16'(n + 1), 16'(tick_cnt - base));
    repeat (3) @(negedge clock_i);
    chk("irq after rise", 16'h1, {15'h0, irq});
    u_ust_host_model.acc(1'b0, OFS_TMR0, 2'b11, 16'h0000, q);
    chk("cfg readback", 16'hb7, {8'h00, q[15:8]});
    u_ust_host_model.acc(1'b0, OFS_IRQ, 2'b11, 16'h0000, q);
    chk("irq source", {8'h01, TB_ID}, q);
    u_ust_host_model.acc(1'b1, OFS_TMR0, 2'b10, 16'h7700, q);
    repeat (2) @(negedge clock_i);
    chk("irq while release set", 16'h1, {15'h0, irq});
    u_ust_host_model.acc(1'b1, OFS_TMR0, 2'b10, 16'h3700, q);
    repeat (2) @(negedge clock_i);
    chk("irq after release", 16'h0, {15'h0, irq});
    u_ust_host_model.acc(1'b1, OFS_GRP_A_CTRL, 2'b01, 16'h0030, q);
    u_ust_host_model.acc(1'b1, OFS_TMR0, 2'b01, 16'(n), q);
    u_ust_host_model.acc(1'b1, OFS_TMR0, 2'b01, 16'h0000, q);
    wait_out(0, 1'b1);
    u_ust_host_model.acc(1'b1, OFS_TMR0, 2'b01, 16'(n), q);
    chk("mode 0 out after first byte", 16'h0, {15'h0, tout[0]});
    tick_en <= 1'b0;
    u_ust_host_model.acc(1'b1, OFS_TMR0, 2'b01, 16'h0000, q);
    base = tick_cnt;
    tick_en <= 1'b1;
    wait_out(0, 1'b1);
    chk("mode 0 reload ticks", 16'(n + 1), 16'(tick_cnt - base));
    $display("mode 0 and interrupt test done");

    rng = xs(rng);
    n = 2 + int'(rng % 8);
    u_ust_host_model.acc(1'b1, OFS_TMR1, 2'b10, 16'h0700, q);
    u_ust_host_model.acc(1'b1, OFS_GRP_A_CTRL, 2'b01, 16'h0054, q);
    chk("mode 2 out after control", 16'h1, {15'h0, tout[1]});
    setup(OFS_TMR1, OFS_GRP_A_CTRL, 8'h54, n, 8'h17);
    wait_out(1, 1'b0);
    chk("mode 2 first pulse", 16'(n), 16'(tick_cnt - base));
    wait_out(1, 1'b1);
    chk("mode 2 pulse width", 16'(n + 1), 16'(tick_cnt - base));
    wait_out(1, 1'b0);
    chk("mode 2 period", 16'(2 * n), 16'(tick_cnt - base));
    $display("mode 2 test done");

    rng = xs(rng);
    n = 2 + int'(rng % 8);
    tick_en <= 1'b0;
    u_ust_host_model.acc(1'b1, OFS_TMR2, 2'b10, 16'h0000, q);
    u_ust_host_model.acc(1'b1, OFS_GRP_A_CTRL, 2'b01, 16'h0094, q);
    u_ust_host_model.acc(1'b1, OFS_TMR2, 2'b01, 16'(n), q);
    u_ust_host_model.acc(1'b1, OFS_TMR2, 2'b10, 16'h1f00, q);
    ms <= 1'b1;
    tick_en <= 1'b1;
    base = tick_cnt;
    @(negedge clock_i);
    ms <= 1'b0;
    wait_out(2, 1'b0);
    wait_out(2, 1'b1);
    chk("sync edge to first rise", 16'(n), 16'(tick_cnt - base));
    wait_out(2, 1'b0);
    wait_out(2, 1'b1);
    chk("sync second rise", 16'(2 * n), 16'(tick_cnt - base));
    $display("sync start test done");
    tally_and_finish();
  end
endmodule // ust_timer_bank_tb_top
